// ===== rtl/rcsel_pkg.sv
package rcsel_pkg;
	// ==========================================================
	// register map (apb byte addresses, one word each)
	localparam logic [11:0] RCSEL_TRIM_OFS   = 12'h000;
	localparam logic [11:0] RCSEL_FUSE_OFS   = 12'h004;
	localparam logic [11:0] RCSEL_STATUS_OFS = 12'h008;
	localparam logic [11:0] RCSEL_CTRL_OFS   = 12'h00C;

	// ==========================================================
	// fuse codes
	localparam logic [3:0] RCSEL_CKSRC_EXT   = 4'h0;
	localparam logic [3:0] RCSEL_CKSRC_RC1   = 4'h1;
	localparam logic [3:0] RCSEL_CKSRC_RC2   = 4'h2;
	localparam logic [3:0] RCSEL_CKSRC_RC4   = 4'h3;
	localparam logic [3:0] RCSEL_CKSRC_RC8   = 4'h4;
	localparam logic [3:0] RCSEL_CKSRC_RESET = 4'h1;
	localparam logic [1:0] RCSEL_SUT_RESET   = 2'h2;
	localparam logic [1:0] RCSEL_SUT_NONE    = 2'h0;
	localparam logic [1:0] RCSEL_SUT_SHORT   = 2'h1;
	localparam logic [1:0] RCSEL_SUT_LONG    = 2'h2;
	localparam logic [1:0] RCSEL_SUT_RSVD    = 2'h3;
	localparam logic [7:0] RCSEL_SIGROW_ADDR = 8'h00;
	localparam logic [7:0] RCSEL_TRIM_RESET  = 8'h00;

	// ==========================================================
	// timing
	localparam int RCSEL_CLK_HZ        = 20000000;
	localparam int RCSEL_WAKE_CK       = 6;
	localparam real RCSEL_SHORT_MS     = 4.1;
	localparam real RCSEL_LONG_MS      = 65.0;
	localparam int RCSEL_SHORT_CYC     = int'($floor(RCSEL_SHORT_MS * RCSEL_CLK_HZ / 1000.0));
	localparam int RCSEL_LONG_CYC      = int'($floor(RCSEL_LONG_MS * RCSEL_CLK_HZ / 1000.0));

	// ==========================================================
	// carriers
	typedef enum logic [3:0] {
		RCSEL_ST_LOAD  = 4'b0001,
		RCSEL_ST_DELAY = 4'b0010,
		RCSEL_ST_WAKE  = 4'b0100,
		RCSEL_ST_RUN   = 4'b1000
	} rcsel_state_type;

	typedef struct packed {
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_time_fuses;
	} rcsel_fuse_type;

	typedef struct packed {
		logic       use_ext;
		logic       use_rc;
		logic [1:0] rc_range;
		logic       clk_gate_open;
	} rcsel_clk_type;
endpackage : rcsel_pkg

// ===== rtl/rcsel_top.sv
// Notes on behaviour
// (R1) fuse codes 1..4 pick rc 1/2/4/8 MHz
// (R2) shipped: rc 1 MHz, slow-rise delay
// (R3) reset copies factory byte into trim
// (R4) reset value is signature row byte 0x00
// (R5) software loads other-frequency trims itself
// (R6) reset delay timed from watchdog oscillator
// (R7) rc: 6 CK wake, 0/4.1/65 ms delays
// (R8) trim write retunes rc at once
// (R9) zero slowest, 0xFF fastest trim
// (R10) trim span 50-200 percent of nominal
// (R11) software keeps trim under 10% when writing
// (R12) external clock only for fuse code 0000
// (R13) external: 6 CK wake, same delays
// (R14) external clock steady or held in reset
// (R15) keep oscillator option fuse unprogrammed with rc
// (R16) gate clock until wake count done
//
// Implementation choices: the APB interface to the registers and the address map.
module rcsel_top (
	// apb clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 clk_en,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic      [31:0]          prdata,
	output logic                      pslverr,
	// fuses and factory signature row
	input  wire rcsel_pkg::rcsel_fuse_type fuses,
	output logic      [7:0]           sigrow_addr,
	input  wire logic [7:0]           sigrow_data,
	// watchdog oscillator tick and selected clock tick, both asynchronous
	input  wire logic                 wdt_osc_tick,
	input  wire logic                 sel_clk_tick,
	// wake request from sleep logic
	input  wire logic                 wake_req,
	// oscillator control
	output logic      [7:0]           rc_trim_register,
	output rcsel_pkg::rcsel_clk_type  clk_ctrl,
	output logic                      sys_reset_hold
);
	import rcsel_pkg::*;

	// ==========================================================
	// state
	rcsel_state_type state_r, state_nxt;
	logic [7:0]  trim_r;
	logic [21:0] dly_cnt_r;
	logic [2:0]  wake_cnt_r;
	logic [3:0]  src_r;
	logic [1:0]  sut_r;
	logic [1:0]  wdt_sync_r, ck_sync_r, wake_sync_r;
	logic        wdt_prev_r, ck_prev_r;
	logic        pready_r, pslverr_r, hold_r;
	logic [31:0] prdata_r;
	rcsel_clk_type clk_r;

	// ==========================================================
	// synchronisers: first stage feeds only the second
	// edge history resets low, the idle level of both ticks, so no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_sync_r  <= 2'h0;
			ck_sync_r   <= 2'h0;
			wake_sync_r <= 2'h0;
			wdt_prev_r  <= 1'b0;
			ck_prev_r   <= 1'b0;
		end else if (clk_en) begin
			wdt_sync_r  <= {wdt_sync_r[0], wdt_osc_tick};
			ck_sync_r   <= {ck_sync_r[0], sel_clk_tick};
			wake_sync_r <= {wake_sync_r[0], wake_req};
			wdt_prev_r  <= wdt_sync_r[1];
			ck_prev_r   <= ck_sync_r[1];
		end
	end

	wire wdt_edge = wdt_sync_r[1] & ~wdt_prev_r;
	wire ck_edge  = ck_sync_r[1] & ~ck_prev_r;
	wire wake_lvl = wake_sync_r[1];

	// ==========================================================
	// fuse decode
	// undefined source codes select neither clock, leaving the core stopped
	wire src_is_ext = (src_r == RCSEL_CKSRC_EXT); // [R12]
	wire src_is_rc  = (src_r >= RCSEL_CKSRC_RC1) && (src_r <= RCSEL_CKSRC_RC8); // [R1]
	wire [1:0] rc_range = 2'(src_r - RCSEL_CKSRC_RC1); // [R1]
	// reserved start-up code falls back to the longest delay, safest choice
	wire [21:0] dly_target =
		(sut_r == RCSEL_SUT_NONE)  ? 22'h0 :
		(sut_r == RCSEL_SUT_SHORT) ? 22'(RCSEL_SHORT_CYC) :
		22'(RCSEL_LONG_CYC); // [R7] [R13]

	// ==========================================================
	// apb decode
	// ready is registered off the setup cycle: one wait-free access, no stalls
	wire apb_setup = psel & ~penable;
	wire apb_acc   = psel & penable & pready_r;
	wire hit_trim  = (paddr == RCSEL_TRIM_OFS);
	wire hit_fuse  = (paddr == RCSEL_FUSE_OFS);
	wire hit_stat  = (paddr == RCSEL_STATUS_OFS);
	wire hit_ctrl  = (paddr == RCSEL_CTRL_OFS);
	wire hit_any   = hit_trim | hit_fuse | hit_stat | hit_ctrl;
	wire trim_wr   = apb_acc & pwrite & hit_trim;
	wire [31:0] rd_mux =
		hit_trim ? {24'h0, trim_r} :
		hit_fuse ? {26'h0, src_r, sut_r} :
		hit_stat ? {28'h0, state_r} :
		hit_ctrl ? {29'h0, hold_r, clk_r.use_ext, clk_r.clk_gate_open} :
		32'h0;

	// ==========================================================
	// sequencer next state
	// load lasts one cycle; run leaves only on a wake request
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			RCSEL_ST_LOAD: state_nxt = RCSEL_ST_DELAY;
			RCSEL_ST_DELAY: if (dly_cnt_r >= dly_target) state_nxt = RCSEL_ST_WAKE;
			RCSEL_ST_WAKE: if (wake_cnt_r >= 3'(RCSEL_WAKE_CK)) state_nxt = RCSEL_ST_RUN;
			RCSEL_ST_RUN: if (wake_lvl) state_nxt = RCSEL_ST_WAKE;
			default: state_nxt = RCSEL_ST_LOAD;
		endcase
	end

	// ==========================================================
	// sequencer and trim
	// fuses are latched once per reset, so a fuse change takes effect at reset only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= RCSEL_ST_LOAD;
			src_r   <= RCSEL_CKSRC_RESET; // [R2]
			sut_r   <= RCSEL_SUT_RESET; // [R2]
			trim_r  <= RCSEL_TRIM_RESET;
		end else if (clk_en) begin
			state_r <= state_nxt;
			if (state_r == RCSEL_ST_LOAD) begin
				src_r  <= fuses.clock_source_select_fuses;
				sut_r  <= fuses.startup_time_fuses;
				trim_r <= sigrow_data; // [R3] [R4]
			end else if (trim_wr) begin
				trim_r <= pwdata[7:0]; // [R8] [R9] [R10]
			end
		end
	end

	// delay counted on watchdog oscillator ticks, not the system clock
	// a 22-bit count covers the longest delay of about 1.3 million ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_r <= 22'h0;
		end else if (clk_en) begin
			if (state_r != RCSEL_ST_DELAY) dly_cnt_r <= 22'h0;
			else if (wdt_edge) dly_cnt_r <= dly_cnt_r + 22'h1; // [R6]
		end
	end

	// wake count runs on edges of the selected source
	// a stopped source simply stalls the count; the gate stays shut meanwhile
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cnt_r <= 3'h0;
		end else if (clk_en) begin
			if (state_r != RCSEL_ST_WAKE) wake_cnt_r <= 3'h0;
			else if (ck_edge) wake_cnt_r <= wake_cnt_r + 3'h1; // [R16]
		end
	end

	// ==========================================================
	// registered outputs
	// every output but the constant sigrow_addr leaves a flip-flop, so consumers see no decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_r     <= '0;
			hold_r    <= 1'b1;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else if (clk_en) begin
			clk_r.use_ext       <= src_is_ext; // [R12]
			clk_r.use_rc        <= src_is_rc; // [R1]
			clk_r.rc_range      <= src_is_rc ? rc_range : 2'h0;
			clk_r.clk_gate_open <= (state_nxt == RCSEL_ST_RUN); // [R16]
			hold_r    <= (state_nxt == RCSEL_ST_LOAD) || (state_nxt == RCSEL_ST_DELAY);
			pready_r  <= apb_setup;
			pslverr_r <= apb_setup & ~hit_any;
			prdata_r  <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// output ports are plain copies of the registers above, except sigrow_addr, which is tied to RCSEL_SIGROW_ADDR
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign prdata           = prdata_r;
	assign rc_trim_register = trim_r;
	assign clk_ctrl         = clk_r;
	assign sys_reset_hold   = hold_r;
	assign sigrow_addr      = RCSEL_SIGROW_ADDR; // [R4]

	// ==========================================================
	// checks
	// load copies the factory byte whatever software wrote before reset
	AST_TRIM_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(clk_en && state_r == RCSEL_ST_LOAD) |=> (trim_r == $past(sigrow_data)))
		else $error("trim not loaded at reset");
	AST_TRIM_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && trim_wr && state_r != RCSEL_ST_LOAD) |=> (trim_r == $past(pwdata[7:0])))
		else $error("trim write lost");
	AST_EXT_ONLY_0: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		clk_r.use_ext |-> ($past(src_r) == RCSEL_CKSRC_EXT))
		else $error("external clock picked for wrong code");
	AST_RC_CODES: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(clk_en && src_r == RCSEL_CKSRC_RC4) |=> (clk_r.use_rc && clk_r.rc_range == 2'h2))
		else $error("rc range decode wrong");
	AST_SHIP_DEFAULT: assert property (@(posedge pclk) // [R2]
		!presetn |-> (src_r == RCSEL_CKSRC_RESET && sut_r == RCSEL_SUT_RESET))
		else $error("shipped defaults wrong");
	AST_GATE_HELD: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(state_r == RCSEL_ST_WAKE && state_nxt == RCSEL_ST_WAKE) |=> !clk_r.clk_gate_open)
		else $error("clock released early");
	AST_NO_DELAY: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(clk_en && state_r == RCSEL_ST_DELAY && sut_r == RCSEL_SUT_NONE) |=>
		state_r == RCSEL_ST_WAKE)
		else $error("zero delay not skipped");
	AST_DELAY_WDT: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(clk_en && state_r == RCSEL_ST_DELAY && !wdt_edge) |=> $stable(dly_cnt_r))
		else $error("delay advanced without watchdog tick");
	AST_WAKE_SIX: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		$rose(clk_r.clk_gate_open) |-> ($past(wake_cnt_r) >= 3'(RCSEL_WAKE_CK)))
		else $error("wake count short");

	// ==========================================================
	// bus answer checks
	// pready is a one-cycle answer; a stuck level would repeat writes
	AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && pready_r) |=> !pready_r)
		else $error("ready held past one cycle");
	// the answer always follows its setup cycle by one clock
	AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && apb_setup) |=> pready_r)
		else $error("setup not answered");
	// an error flag only ever travels with the answer
	AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		pslverr_r |-> pready_r)
		else $error("error flag without ready");
	// unmapped offsets are refused rather than silently read as zero
	AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && apb_setup && !hit_any) |=> pslverr_r)
		else $error("unmapped access not refused");
	// read data is zero outside the answer, so old bytes never leak
	AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		!pready_r |-> (prdata_r == 32'h0))
		else $error("read data outside answer");
	// a trim read returns the trim as it stood in the setup cycle
	AST_TRIM_READBACK: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && apb_setup && !pwrite && hit_trim) |=>
		(prdata_r == {24'h0, $past(trim_r)}))
		else $error("trim read back wrong");
	// writes to the other words must never reach the trim
	AST_TRIM_ONLY_OWN: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && apb_acc && pwrite && !hit_trim && state_r != RCSEL_ST_LOAD) |=>
		$stable(trim_r))
		else $error("foreign write changed trim");
	// outside load and own writes the trim keeps its value
	AST_TRIM_STEADY: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && state_r != RCSEL_ST_LOAD && !trim_wr) |=> $stable(trim_r))
		else $error("trim drifted");

	// ==========================================================
	// sequencer checks
	// hold stays up through load and delay so the core never runs early
	AST_HOLD_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(state_r == RCSEL_ST_LOAD) |-> hold_r)
		else $error("hold low in load");
	AST_HOLD_DELAY: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(state_r == RCSEL_ST_DELAY) |-> hold_r)
		else $error("hold low in delay");
	// hold drops as soon as the wake count runs
	AST_HOLD_FREE_WAKE: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		(clk_en && state_r == RCSEL_ST_WAKE) |=> !hold_r)
		else $error("hold kept past delay");
	// load lasts exactly one enabled cycle
	AST_LOAD_ONCE: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(clk_en && state_r == RCSEL_ST_LOAD) |=> (state_r == RCSEL_ST_DELAY))
		else $error("load state lingered");
	// the fuses are latched once; a later change must wait for reset
	AST_FUSE_LOCKED: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(clk_en && state_r != RCSEL_ST_LOAD) |=> ($stable(src_r) && $stable(sut_r)))
		else $error("fuse copy changed after load");
	// every delay starts from a cleared count
	AST_DELAY_ENTRY: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(clk_en && state_r == RCSEL_ST_LOAD) |=> (dly_cnt_r == 22'h0))
		else $error("delay count not cleared");
	// reserved start-up code behaves as the longest delay
	AST_RSVD_LONG: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(sut_r == RCSEL_SUT_RSVD) |-> (dly_target == 22'(RCSEL_LONG_CYC)))
		else $error("reserved code not longest delay");
	AST_SHORT_TARGET: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		(sut_r == RCSEL_SUT_SHORT) |-> (dly_target == 22'(RCSEL_SHORT_CYC)))
		else $error("short delay target wrong");
	// a wake request in run restarts the count from zero
	AST_WAKE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(clk_en && state_r == RCSEL_ST_RUN && wake_lvl) |=>
		(state_r == RCSEL_ST_WAKE && wake_cnt_r == 3'h0))
		else $error("wake not restarted");
	// only source edges move the wake count, never pclk alone
	AST_WAKE_CK_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(clk_en && state_r == RCSEL_ST_WAKE && !ck_edge) |=> $stable(wake_cnt_r))
		else $error("wake count moved without edge");
	// the gate is open exactly while the sequencer runs
	AST_GATE_RUN: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		clk_r.clk_gate_open == (state_r == RCSEL_ST_RUN))
		else $error("gate and state disagree");

	// ==========================================================
	// source decode checks
	// never both sources at once, the switch would glitch
	AST_EXT_EXCL: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		!(clk_r.use_ext && clk_r.use_rc))
		else $error("both sources selected");
	AST_EXT_PICKED: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(clk_en && src_r == RCSEL_CKSRC_EXT) |=> (clk_r.use_ext && !clk_r.use_rc))
		else $error("external clock not picked");
	// both ends of the rc range decode, not only the middle
	AST_RC1_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(clk_en && src_r == RCSEL_CKSRC_RC1) |=> (clk_r.use_rc && clk_r.rc_range == 2'h0))
		else $error("rc 1 MHz decode wrong");
	AST_RC8_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(clk_en && src_r == RCSEL_CKSRC_RC8) |=> (clk_r.use_rc && clk_r.rc_range == 2'h3))
		else $error("rc 8 MHz decode wrong");

	// ==========================================================
	// scenario covers
	COV_RUN: cover property (@(posedge pclk) disable iff (!presetn) $rose(clk_r.clk_gate_open));
	COV_WAKE: cover property (@(posedge pclk) disable iff (!presetn)
		state_r == RCSEL_ST_RUN ##1 state_r == RCSEL_ST_WAKE);
	COV_TRIM: cover property (@(posedge pclk) disable iff (!presetn) trim_wr);
	COV_EXT: cover property (@(posedge pclk) disable iff (!presetn) clk_r.use_ext);
	COV_RSVD: cover property (@(posedge pclk) disable iff (!presetn)
		state_r == RCSEL_ST_DELAY && sut_r == RCSEL_SUT_RSVD);
endmodule : rcsel_top

// ===== sim/rcsel_ext_clk_model.sv
// ==========================================================
// far side: external clock source and watchdog oscillator
module rcsel_ext_clk_model (
	// run control from the bench
	input  wire logic run,
	// oscillator outputs
	output logic      sel_clk_tick,
	output logic      wdt_osc_tick
);
	timeunit 1ns;
	timeprecision 100ps;
	import rcsel_pkg::*;

	// watchdog oscillator free-runs, unrelated to pclk
	initial wdt_osc_tick = 1'h0;
	always #75 wdt_osc_tick = ~wdt_osc_tick;

	// fixed period; stands low while stopped, never drifts mid-run
	initial sel_clk_tick = 1'h0;
	always #190 sel_clk_tick = run ? ~sel_clk_tick : 1'h0;
endmodule : rcsel_ext_clk_model

// ===== sim/tb_rc_osc_clock_select_trim.sv
// ==========================================================
// bench for clock select, start-up and trim
module tb_rc_osc_clock_select_trim;
	timeunit 1ns;
	timeprecision 100ps;
	import rcsel_pkg::*;

	// presetn starts high so the first reset is a real falling edge
	logic           pclk = 0, presetn = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic           wake_req = 0, run = 1, err, pready, pslverr, sys_reset_hold, wdt, sel;
	logic [11:0]    paddr = '0;
	logic [31:0]    pwdata = '0, rd, prdata;
	logic [7:0]     sig = 8'hA5, sigrow_addr, rc_trim_register;
	rcsel_fuse_type fz = '0;
	rcsel_clk_type  clk_ctrl;
	int             failures = 0, compares = 0;

	// 20 MHz clock
	always #25 pclk = ~pclk;

	rcsel_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .fuses(fz), .sigrow_addr(sigrow_addr),
		.sigrow_data(sig), .wdt_osc_tick(wdt), .sel_clk_tick(sel), .wake_req(wake_req),
		.rc_trim_register(rc_trim_register), .clk_ctrl(clk_ctrl),
		.sys_reset_hold(sys_reset_hold));
	rcsel_ext_clk_model i_src (.run(run), .sel_clk_tick(sel), .wdt_osc_tick(wdt));

	// ==========================================================
	// helpers
	task automatic stop_test();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// apb master: hold request until pready is sampled, bounded wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n = 0;
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) begin failures++; stop_test(); end
		r = prdata;
		e = pslverr;
		psel <= 1'h0; penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	// reset with new fuses; 16 cycles low, trim must follow the factory byte
	// the oscillator option fuse is not modelled and stays unprogrammed
	task automatic rst(input logic [3:0] s, input logic [1:0] t);
		presetn <= 1'h0;
		fz <= {s, t};
		repeat (16) @(posedge pclk);
		chk("trim_in_reset", rc_trim_register, RCSEL_TRIM_RESET);
		chk("hold_in_reset", sys_reset_hold, 1'h1);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		chk("trim_loaded", rc_trim_register, sig);
		chk("sigrow_addr", sigrow_addr, RCSEL_SIGROW_ADDR);
	endtask : rst

	task automatic wait_gate();
		int n = 0;
		while (clk_ctrl.clk_gate_open !== 1'h1) begin
			@(posedge pclk);
			n++;
			if (n > 400) begin failures++; stop_test(); end
		end
	endtask : wait_gate

	// ==========================================================
	// scenarios
	task automatic t_decode();
		for (int i = 0; i < 6; i++) begin
			rst(4'(i), RCSEL_SUT_NONE);
			if (i < 5) wait_gate();
			else repeat (150) @(posedge pclk);
			chk("use_ext", clk_ctrl.use_ext, i == 0);
			chk("use_rc", clk_ctrl.use_rc, i inside {[1:4]});
			if (i inside {[1:4]}) chk("rc_range", clk_ctrl.rc_range, i - 1);
			if (i < 5) chk("hold_free", sys_reset_hold, 1'h0);
			apb(1'h0, RCSEL_FUSE_OFS, '0, rd, err);
			chk("fuse_reg", rd, {26'h0, 4'(i), RCSEL_SUT_NONE});
		end
	endtask : t_decode

	// nonzero delay codes keep reset held long after release
	task automatic t_delay();
		for (int t = 1; t < 4; t++) begin
			rst(t == 2 ? RCSEL_CKSRC_RESET : RCSEL_CKSRC_EXT, 2'(t));
			repeat (200) @(posedge pclk);
			chk("hold_delay", sys_reset_hold, 1'h1);
			chk("gate_delay", clk_ctrl.clk_gate_open, 1'h0);
		end
	endtask : t_delay

	// wake from run: gate closed until six source edges are seen
	task automatic t_wake();
		int n = 0;
		int e = 0;
		logic p = 0;
		rst(RCSEL_CKSRC_RC8, RCSEL_SUT_NONE);
		wait_gate();
		apb(1'h0, RCSEL_STATUS_OFS, '0, rd, err);
		chk("status_run", rd, {28'h0, RCSEL_ST_RUN});
		// frozen block must ignore the wake request while the enable is low
		clk_en <= 1'h0;
		wake_req <= 1'h1;
		repeat (10) @(posedge pclk);
		chk("frozen_gate", clk_ctrl.clk_gate_open, 1'h1);
		clk_en <= 1'h1;
		run <= 1'h0;
		repeat (4) @(posedge pclk);
		wake_req <= 1'h0;
		repeat (40) @(posedge pclk);
		chk("gate_stopped", clk_ctrl.clk_gate_open, 1'h0);
		run <= 1'h1;
		while (clk_ctrl.clk_gate_open !== 1'h1 && n < 400) begin
			@(posedge pclk);
			if (sel && !p) e++;
			p = sel;
			n++;
		end
		if (clk_ctrl.clk_gate_open !== 1'h1) begin
			failures++;
			stop_test();
		end
		chk("wake_edges", e, RCSEL_WAKE_CK);
	endtask : t_wake

	// software retunes the trim; extremes and mid value
	// no non-volatile write runs here, so trims above +10% are allowed
	task automatic t_trim();
		logic [7:0] v [3] = '{8'hFF, 8'h00, 8'h7F};
		sig <= 8'h3C;
		rst(RCSEL_CKSRC_RC2, RCSEL_SUT_NONE);
		foreach (v[k]) begin
			apb(1'h1, RCSEL_TRIM_OFS, {24'h5A5A5A, v[k]}, rd, err);
			chk("trim_err", err, 1'h0);
			chk("trim_out", rc_trim_register, v[k]);
			apb(1'h0, RCSEL_TRIM_OFS, '0, rd, err);
			chk("trim_read", rd, {24'h0, v[k]});
		end
		apb(1'h1, RCSEL_FUSE_OFS, 32'hFFFFFFFF, rd, err);
		apb(1'h0, RCSEL_FUSE_OFS, '0, rd, err);
		chk("fuse_ro", rd, {26'h0, RCSEL_CKSRC_RC2, RCSEL_SUT_NONE});
		apb(1'h0, 12'h010, '0, rd, err);
		chk("unmapped_err", err, 1'h1);
	endtask : t_trim

	// main sequence
	initial begin
		t_decode();
		t_delay();
		t_wake();
		t_trim();
		stop_test();
	end
endmodule : tb_rc_osc_clock_select_trim
